//--- dv/adc_result_compare_tb.sv
`timescale 1ns/10ps
module adc_result_compare_tb;
  import adc_cmp_pkg::*;
  logic aclk;
  logic aresetn;
  logic [ADDR_W-1:0] awaddr;
  logic awvalid;
  logic awready;
  logic [DATA_W-1:0] wdata;
  logic wvalid;
  logic wready;
  logic [1:0] bresp;
  logic bvalid;
  logic bready;
  logic [ADDR_W-1:0] araddr;
  logic arvalid;
  logic arready;
  logic [DATA_W-1:0] rdata;
  logic [1:0] rresp;
  logic rvalid;
  logic rready;
  logic res_valid;
  logic [CH_W-1:0] res_ch;
  logic [RES_W-1:0] res_data;
  logic irq;
  int errors;
  int num_checks;
  int seed;
  logic [33:0] rq[$];
  logic [1:0] bq[$];

  adc_result_compare i_dut (
    .aclk(aclk), .aresetn(aresetn),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .result_valid(res_valid), .result_channel(res_ch), .result_data(res_data), .irq(irq)
  );

  initial begin
    aclk = 1'b0;
    forever #20 aclk = ~aclk;
  end

  task summarize;
    $display("checks %0d errors %0d", num_checks, errors);
    if (errors == 0 && num_checks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  task fail(input string m);
    errors++;
    $display("[FAIL] %0t %s", $time, m);
  endtask

  task chk_rd(input logic [33:0] got);
    num_checks++;
    if (rq.size() == 0) fail("unexpected read");
    else if (got !== rq.pop_front()) fail("read data or response mismatch");
  endtask

  task chk_b(input logic [1:0] got);
    num_checks++;
    if (bq.size() == 0) fail("unexpected write response");
    else if (got !== bq.pop_front()) fail("write response mismatch");
  endtask

  task chk_irq(input logic e);
    num_checks++;
    if (irq !== e) fail("interrupt level mismatch");
  endtask

  // Results are judged where the handshake completes, oldest note first
  always @(posedge aclk) begin
    if (aresetn === 1'b1 && rvalid === 1'b1 && rready === 1'b1) chk_rd({rresp, rdata});
    if (aresetn === 1'b1 && bvalid === 1'b1 && bready === 1'b1) chk_b(bresp);
  end

  task wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r = RESP_OKAY);
    bit aw;
    bit w;
    bit done;
    int n;
    bq.push_back(r);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    aw = 0;
    w = 0;
    n = 0;
    do begin
      @(posedge aclk);
      if (!aw && awready === 1'b1) begin
        aw = 1;
        awvalid <= 1'b0;
      end
      if (!w && wready === 1'b1) begin
        w = 1;
        wvalid <= 1'b0;
      end
      done = (bvalid === 1'b1);
      n++;
    end while (!done && n < 64);
    if (!done) begin
      fail("write timeout");
      summarize();
    end
  endtask

  task rd(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r = RESP_OKAY);
    bit ar;
    bit done;
    int n;
    rq.push_back({r, d});
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    ar = 0;
    n = 0;
    do begin
      @(posedge aclk);
      if (!ar && arready === 1'b1) begin
        ar = 1;
        arvalid <= 1'b0;
      end
      done = (rvalid === 1'b1);
      n++;
    end while (!done && n < 64);
    if (!done) begin
      fail("read timeout");
      summarize();
    end
  endtask

  task feed(input logic v, input logic [2:0] ch, input logic [11:0] d);
    res_valid <= v;
    res_ch <= ch;
    res_data <= d;
    @(posedge aclk);
  endtask

  function automatic logic [31:0] cw(input logic [2:0] f, input logic [2:0] ch,
                                     input logic [3:0] lim, input logic [11:0] thr);
    return {4'h0, thr, 4'h0, lim, 2'h0, ch, f};
  endfunction

  initial begin
    logic [31:0] d;
    seed = 32'hb07142fe;
    errors = 0;
    num_checks = 0;
    {awaddr, awvalid, wdata, wvalid, bready, araddr, arvalid, rready} = '0;
    {res_valid, res_ch, res_data} = '0;
    aresetn = 1'b0;
    repeat (3) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    for (int i = 0; i < 6; i++) rd(CTRL0_OFS + 8'(4 * i), 32'h0);
    rd(8'h40, 32'h0, RESP_SLVERR);
    wr(8'h40, 32'hffffffff, RESP_SLVERR);
    for (int i = 0; i < 2; i++) begin
      d = $random(seed);
      wr(CTRL0_OFS + 8'(4 * i), d);
      rd(CTRL0_OFS + 8'(4 * i), d & CTRL_RW_MASK);
    end
    wr(CTRL1_OFS, 32'h0);
    $display("test reset and access done");
    wr(MASK_OFS, 32'h3);
    wr(CTRL0_OFS, cw(3'h1, 3'h3, 4'h1, 12'h100));
    feed(1'b1, 3'h3, 12'h050);
    feed(1'b1, 3'h3, 12'h100);
    feed(1'b1, 3'h3, 12'h050);
    feed(1'b0, 3'h0, 12'h000);
    repeat (3) @(posedge aclk);
    rd(STATUS_OFS, 32'h0);
    feed(1'b1, 3'h2, 12'h000);
    feed(1'b1, 3'h3, 12'h0ff);
    feed(1'b0, 3'h0, 12'h000);
    repeat (3) @(posedge aclk);
    rd(STATUS_OFS, 32'h2);
    chk_irq(1'b0);
    rd(EVT_OFS, 32'h1);
    wr(STATUS_OFS, 32'h0);
    rd(STATUS_OFS, 32'h2);
    wr(STATUS_OFS, 32'h2);
    rd(STATUS_OFS, 32'h0);
    $display("test below threshold done");
    wr(MASK_OFS, 32'h0);
    wr(CTRL1_OFS, cw(3'h7, 3'h7, 4'h0, 12'h800));
    feed(1'b1, 3'h7, 12'h7ff);
    feed(1'b0, 3'h0, 12'h000);
    repeat (3) @(posedge aclk);
    rd(STATUS_OFS, 32'h0);
    feed(1'b1, 3'h7, 12'h800);
    feed(1'b0, 3'h0, 12'h000);
    repeat (4) @(posedge aclk);
    rd(STATUS_OFS, 32'h4);
    chk_irq(1'b0);
    wr(MASK_OFS, 32'h2);
    repeat (2) @(posedge aclk);
    chk_irq(1'b1);
    rd(EVT_OFS, 32'h2);
    repeat (2) @(posedge aclk);
    chk_irq(1'b0);
    rd(EVT_OFS, 32'h0);
    wr(STATUS_OFS, 32'h4);
    wr(CTRL1_OFS, 32'h0);
    $display("test at or above threshold done");
    wr(FMT_OFS, 32'h1);
    wr(MASK_OFS, 32'h1);
    wr(CTRL0_OFS, cw(3'h7, 3'h0, 4'h0, 12'hf00));
    feed(1'b1, 3'h0, 12'h000);
    feed(1'b0, 3'h0, 12'h000);
    repeat (3) @(posedge aclk);
    chk_irq(1'b1);
    rd(EVT_OFS, 32'h1);
    rd(STATUS_OFS, 32'h2);
    wr(STATUS_OFS, 32'h2);
    wr(CTRL0_OFS, cw(3'h1, 3'h0, 4'h0, 12'h000));
    feed(1'b1, 3'h0, 12'h800);
    feed(1'b0, 3'h0, 12'h000);
    repeat (3) @(posedge aclk);
    rd(STATUS_OFS, 32'h2);
    wr(STATUS_OFS, 32'h2);
    wr(FMT_OFS, 32'h0);
    feed(1'b1, 3'h0, 12'h800);
    feed(1'b0, 3'h0, 12'h000);
    repeat (3) @(posedge aclk);
    rd(STATUS_OFS, 32'h0);
    $display("test result format done");
    wr(CTRL0_OFS, cw(3'h5, 3'h5, 4'h1, 12'h000));
    feed(1'b1, 3'h5, 12'($random(seed)));
    feed(1'b0, 3'h0, 12'h000);
    wr(CTRL0_OFS, cw(3'h4, 3'h5, 4'h1, 12'h000));
    feed(1'b1, 3'h5, 12'($random(seed)));
    feed(1'b0, 3'h0, 12'h000);
    wr(CTRL0_OFS, cw(3'h5, 3'h5, 4'h1, 12'h000));
    feed(1'b1, 3'h5, 12'($random(seed)));
    feed(1'b0, 3'h0, 12'h000);
    repeat (3) @(posedge aclk);
    rd(STATUS_OFS, 32'h0);
    feed(1'b1, 3'h5, 12'($random(seed)));
    feed(1'b0, 3'h0, 12'h000);
    repeat (3) @(posedge aclk);
    rd(STATUS_OFS, 32'h2);
    wr(STATUS_OFS, 32'h2);
    $display("test enable done");
    for (int c = 0; c < 8; c++) begin
      wr(CTRL0_OFS, cw(3'h5, 3'(c), 4'h0, 12'h000));
      feed(1'b1, 3'(c + 1), 12'($random(seed)));
      feed(1'b0, 3'h0, 12'h000);
      repeat (3) @(posedge aclk);
      rd(STATUS_OFS, 32'h0);
      feed(1'b1, 3'(c), 12'($random(seed)));
      feed(1'b0, 3'h0, 12'h000);
      repeat (3) @(posedge aclk);
      rd(STATUS_OFS, 32'h2);
      wr(STATUS_OFS, 32'h2);
    end
    $display("test channel select done");
    summarize();
  end
endmodule

//--- hw/adc_result_compare.sv
`timescale 1ns/10ps
module adc_result_compare
  import adc_cmp_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [DATA_W-1:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [DATA_W-1:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic result_valid,
  input wire logic [CH_W-1:0] result_channel,
  input wire logic [RES_W-1:0] result_data,
  output logic irq
);
  logic awready_ff;
  logic wready_ff;
  logic bvalid_ff;
  logic [1:0] bresp_ff;
  logic arready_ff;
  logic rvalid_ff;
  logic [1:0] rresp_ff;
  logic [DATA_W-1:0] rdata_ff;
  logic irq_ff;

  logic aw_got_ff;
  logic w_got_ff;
  logic [ADDR_W-1:0] waddr_ff;
  logic [DATA_W-1:0] wdata_ff;
  logic [3:0] wstrb_ff;

  logic [DATA_W-1:0] ctrl_ff [NUM_UNITS];
  logic [NUM_UNITS-1:0] flag_ff;
  logic [NUM_UNITS-1:0] evt_ff;
  logic [NUM_UNITS-1:0] mask_ff;
  logic fmt_ff;

  logic aw_hs;
  logic w_hs;
  logic ar_hs;
  logic do_write;
  logic nxt_aw_got;
  logic nxt_w_got;
  logic nxt_bvalid;
  logic nxt_rvalid;
  logic [DATA_W-1:0] wmask;
  logic [DATA_W-1:0] nxt_rdata;
  logic rd_hit;
  logic wr_hit;
  logic [NUM_UNITS-1:0] hit;
  logic [NUM_UNITS-1:0] irq_en;
  logic [NUM_UNITS-1:0] flag_clr;
  logic [NUM_UNITS-1:0] evt_clr;

  assign aw_hs = s_axi_awvalid && awready_ff;
  assign w_hs = s_axi_wvalid && wready_ff;
  assign ar_hs = s_axi_arvalid && arready_ff;
  assign do_write = aw_got_ff && w_got_ff && !bvalid_ff;

  assign nxt_aw_got = do_write ? 1'b0 : (aw_hs ? 1'b1 : aw_got_ff);
  assign nxt_w_got = do_write ? 1'b0 : (w_hs ? 1'b1 : w_got_ff);
  assign nxt_bvalid = do_write ? 1'b1 : ((bvalid_ff && s_axi_bready) ? 1'b0 : bvalid_ff);
  assign nxt_rvalid = ar_hs ? 1'b1 : ((rvalid_ff && s_axi_rready) ? 1'b0 : rvalid_ff);

  // Byte lanes of the held write
  genvar b;
  generate
    for (b = 0; b < 4; b++) begin : g_lane
      assign wmask[b*8 +: 8] = {8{wstrb_ff[b]}};
    end
  endgenerate

  // Write address and data channels, taken in either order
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_got_ff <= 1'b0;
      waddr_ff <= {ADDR_W{1'b0}};
    end else begin
      aw_got_ff <= nxt_aw_got;
      if (aw_hs) begin
        waddr_ff <= s_axi_awaddr;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      w_got_ff <= 1'b0;
      wdata_ff <= {DATA_W{1'b0}};
      wstrb_ff <= 4'h0;
    end else begin
      w_got_ff <= nxt_w_got;
      if (w_hs) begin
        wdata_ff <= s_axi_wdata;
        wstrb_ff <= s_axi_wstrb;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      awready_ff <= 1'b0;
      wready_ff <= 1'b0;
      bvalid_ff <= 1'b0;
      bresp_ff <= RESP_OKAY;
    end else begin
      awready_ff <= !nxt_aw_got && !nxt_bvalid;
      wready_ff <= !nxt_w_got && !nxt_bvalid;
      bvalid_ff <= nxt_bvalid;
      if (do_write) begin
        bresp_ff <= wr_hit ? RESP_OKAY : RESP_SLVERR;
      end
    end
  end

  always_comb begin
    wr_hit = 1'b1;
    case (waddr_ff)
      CTRL0_OFS, CTRL1_OFS, STATUS_OFS, EVT_OFS, MASK_OFS, FMT_OFS: wr_hit = 1'b1;
      default: wr_hit = 1'b0;
    endcase
  end

  // Compare control registers
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctrl_ff[0] <= CTRL_RESET;
      ctrl_ff[1] <= CTRL_RESET;
    end else if (do_write) begin
      if (waddr_ff == CTRL0_OFS) begin
        ctrl_ff[0] <= (ctrl_ff[0] & ~wmask) | (wdata_ff & wmask & CTRL_RW_MASK);
      end
      if (waddr_ff == CTRL1_OFS) begin
        ctrl_ff[1] <= (ctrl_ff[1] & ~wmask) | (wdata_ff & wmask & CTRL_RW_MASK);
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      mask_ff <= UNITS_ZERO;
      fmt_ff <= 1'b0;
    end else if (do_write && wstrb_ff[0]) begin
      if (waddr_ff == MASK_OFS) begin
        mask_ff <= wdata_ff[NUM_UNITS-1:0];
      end
      if (waddr_ff == FMT_OFS) begin
        fmt_ff <= wdata_ff[FMT_BIT];
      end
    end
  end

  // Two compare units fed with the converter's result stream
  genvar g;
  generate
    for (g = 0; g < NUM_UNITS; g++) begin : g_unit
      cmp_unit_if cu ();
      assign cu.enable = ctrl_ff[g][EN_BIT];
      assign cu.cond = ctrl_ff[g][COND_BIT];
      assign cu.chan = ctrl_ff[g][CH_MSB:CH_LSB];
      assign cu.limit = ctrl_ff[g][LIM_MSB:LIM_LSB];
      assign cu.thr = ctrl_ff[g][THR_MSB:THR_LSB];
      assign cu.fmt = fmt_ff;
      assign cu.res_valid = result_valid;
      assign cu.res_ch = result_channel;
      assign cu.res_data = result_data;
      assign hit[g] = cu.hit;
      assign irq_en[g] = ctrl_ff[g][IE_BIT];
      compare_unit u_unit (
        .aclk(aclk),
        .aresetn(aresetn),
        .u(cu.unit)
      );
    end
  endgenerate

  // Flags clear by writing one; a hit in the same cycle wins
  assign flag_clr = (do_write && waddr_ff == STATUS_OFS && wstrb_ff[0]) ?
                    {wdata_ff[FLAG1_BIT], wdata_ff[FLAG0_BIT]} : UNITS_ZERO;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      flag_ff <= UNITS_ZERO;
    end else begin
      flag_ff <= hit | (flag_ff & ~flag_clr);
    end
  end

  // Event bits clear when read; a hit in the same cycle wins
  assign evt_clr = (ar_hs && s_axi_araddr == EVT_OFS) ? {NUM_UNITS{1'b1}} : UNITS_ZERO;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      evt_ff <= UNITS_ZERO;
    end else begin
      evt_ff <= hit | (evt_ff & ~evt_clr);
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      irq_ff <= 1'b0;
    end else begin
      irq_ff <= |(evt_ff & mask_ff & irq_en & flag_ff);
    end
  end

  // Read channel
  always_comb begin
    nxt_rdata = {DATA_W{1'b0}};
    rd_hit = 1'b1;
    case (s_axi_araddr)
      CTRL0_OFS: nxt_rdata = ctrl_ff[0];
      CTRL1_OFS: nxt_rdata = ctrl_ff[1];
      STATUS_OFS: begin
        nxt_rdata[FLAG0_BIT] = flag_ff[0];
        nxt_rdata[FLAG1_BIT] = flag_ff[1];
      end
      EVT_OFS: nxt_rdata[NUM_UNITS-1:0] = evt_ff;
      MASK_OFS: nxt_rdata[NUM_UNITS-1:0] = mask_ff;
      FMT_OFS: nxt_rdata[FMT_BIT] = fmt_ff;
      default: rd_hit = 1'b0;
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      arready_ff <= 1'b0;
      rvalid_ff <= 1'b0;
      rdata_ff <= {DATA_W{1'b0}};
      rresp_ff <= RESP_OKAY;
    end else begin
      arready_ff <= !nxt_rvalid;
      rvalid_ff <= nxt_rvalid;
      if (ar_hs) begin
        rdata_ff <= nxt_rdata;
        rresp_ff <= rd_hit ? RESP_OKAY : RESP_SLVERR;
      end
    end
  end

  assign s_axi_awready = awready_ff;
  assign s_axi_wready = wready_ff;
  assign s_axi_bvalid = bvalid_ff;
  assign s_axi_bresp = bresp_ff;
  assign s_axi_arready = arready_ff;
  assign s_axi_rvalid = rvalid_ff;
  assign s_axi_rdata = rdata_ff;
  assign s_axi_rresp = rresp_ff;
  assign irq = irq_ff;

  a_flag0_on_hit: assert property (@(posedge aclk) disable iff (!aresetn)
    hit[0] |=> flag_ff[0] && $past(g_unit[0].cu.enable, 2))
    else $error("unit 0 hit did not set status bit 1");
  a_flag1_on_hit: assert property (@(posedge aclk) disable iff (!aresetn)
    hit[1] |=> flag_ff[1]) else $error("unit 1 hit did not set status bit 2");
  a_flag_sticky: assert property (@(posedge aclk) disable iff (!aresetn)
    flag_ff[0] && !flag_clr[0] |=> flag_ff[0]) else $error("flag dropped without clear");
  a_flag_w1c: assert property (@(posedge aclk) disable iff (!aresetn)
    flag_clr[1] && !hit[1] |=> !flag_ff[1]) else $error("write one did not clear flag");
  a_irq_needs_ie: assert property (@(posedge aclk) disable iff (!aresetn)
    irq_en == UNITS_ZERO [*2] |-> !irq_ff) else $error("interrupt with enables clear");
  a_irq_raised: assert property (@(posedge aclk) disable iff (!aresetn)
    hit[0] && irq_en[0] && mask_ff[0] ##1 irq_en[0] && mask_ff[0] |=> irq_ff)
    else $error("enabled flag gave no interrupt");
  a_irq1_raised: assert property (@(posedge aclk) disable iff (!aresetn)
    hit[1] && irq_en[1] && mask_ff[1] ##1 irq_en[1] && mask_ff[1] |=> irq_ff)
    else $error("enabled flag gave no interrupt");
  a_irq_needs_flag: assert property (@(posedge aclk) disable iff (!aresetn)
    irq_ff |-> $past((flag_ff & irq_en) != UNITS_ZERO)) else $error("interrupt without flag");
  a_flag1_sticky: assert property (@(posedge aclk) disable iff (!aresetn)
    flag_ff[1] && !flag_clr[1] |=> flag_ff[1]) else $error("flag dropped without clear");
  a_flag0_w1c: assert property (@(posedge aclk) disable iff (!aresetn)
    flag_clr[0] && !hit[0] |=> !flag_ff[0]) else $error("write one did not clear flag");
  a_flag0_no_cause: assert property (@(posedge aclk) disable iff (!aresetn)
    !flag_ff[0] && !hit[0] |=> !flag_ff[0]) else $error("unit 0 flag set without hit");
  a_flag1_no_cause: assert property (@(posedge aclk) disable iff (!aresetn)
    !flag_ff[1] && !hit[1] |=> !flag_ff[1]) else $error("unit 1 flag set without hit");
  a_evt_read_clear: assert property (@(posedge aclk) disable iff (!aresetn)
    ar_hs && s_axi_araddr == EVT_OFS && hit == UNITS_ZERO |=> evt_ff == UNITS_ZERO)
    else $error("event bits not cleared by read");

  // Register bus: answers stand until taken, one transfer of each kind at a time
  a_bvalid_holds: assert property (@(posedge aclk) disable iff (!aresetn)
    bvalid_ff && !s_axi_bready |=> bvalid_ff && bresp_ff == $past(bresp_ff))
    else $error("write response dropped before taken");
  a_write_answered: assert property (@(posedge aclk) disable iff (!aresetn)
    aw_got_ff && w_got_ff && !bvalid_ff |=> bvalid_ff)
    else $error("write not answered after both halves");
  a_write_busy: assert property (@(posedge aclk) disable iff (!aresetn)
    bvalid_ff |-> !awready_ff && !wready_ff)
    else $error("write channels ready while response pending");
  a_rvalid_holds: assert property (@(posedge aclk) disable iff (!aresetn)
    rvalid_ff && !s_axi_rready |=> rvalid_ff && rdata_ff == $past(rdata_ff))
    else $error("read data dropped before taken");
  a_read_answered: assert property (@(posedge aclk) disable iff (!aresetn)
    ar_hs |=> rvalid_ff && !arready_ff)
    else $error("read not answered in one cycle");
  a_unmapped_read: assert property (@(posedge aclk) disable iff (!aresetn)
    ar_hs && !rd_hit |=> rresp_ff == RESP_SLVERR && rdata_ff == {DATA_W{1'b0}})
    else $error("unmapped read not refused");
  a_status_read: assert property (@(posedge aclk) disable iff (!aresetn)
    ar_hs && s_axi_araddr == STATUS_OFS
    |=> rdata_ff[FLAG0_BIT] == $past(flag_ff[0]) && rdata_ff[FLAG1_BIT] == $past(flag_ff[1]))
    else $error("status read does not show flags");
  a_ctrl0_write: assert property (@(posedge aclk) disable iff (!aresetn)
    do_write && waddr_ff == CTRL0_OFS && &wstrb_ff
    |=> ctrl_ff[0] == ($past(wdata_ff) & CTRL_RW_MASK)) else $error("control write lost");
  a_ctrl_reserved: assert property (@(posedge aclk) disable iff (!aresetn)
    (ctrl_ff[0] & ~CTRL_RW_MASK) == {DATA_W{1'b0}}
    && (ctrl_ff[1] & ~CTRL_RW_MASK) == {DATA_W{1'b0}})
    else $error("reserved control bits set");
  a_mask_write: assert property (@(posedge aclk) disable iff (!aresetn)
    do_write && waddr_ff == MASK_OFS && wstrb_ff[0]
    |=> mask_ff == $past(wdata_ff[NUM_UNITS-1:0])) else $error("mask write lost");
  a_fmt_write: assert property (@(posedge aclk) disable iff (!aresetn)
    do_write && waddr_ff == FMT_OFS && wstrb_ff[0]
    |=> fmt_ff == $past(wdata_ff[FMT_BIT])) else $error("format write lost");
endmodule

//--- hw/compare_unit.sv
`timescale 1ns/10ps
module compare_unit
  import adc_cmp_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  cmp_unit_if.unit u
);
  logic [LIM_W-1:0] count_ff;
  logic hit_ff;
  logic sel;
  logic below;
  logic match;

  assign sel = u.res_valid && u.enable && (u.res_ch == u.chan);
  // Signed view only when the converter delivers two's-complement results
  assign below = u.fmt ? ($signed(u.res_data) < $signed(u.thr)) : (u.res_data < u.thr);
  assign match = u.cond ? !below : below;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      count_ff <= COUNT_ZERO;
    end else if (!u.enable) begin
      count_ff <= COUNT_ZERO;
    end else if (sel) begin
      if (!match) begin
        count_ff <= COUNT_ZERO;
      end else if (count_ff == u.limit) begin
        count_ff <= COUNT_ZERO;
      end else begin
        count_ff <= LIM_W'(count_ff + COUNT_ONE);
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      hit_ff <= 1'b0;
    end else begin
      hit_ff <= sel && match && (count_ff == u.limit);
    end
  end

  assign u.hit = hit_ff;
  assign u.count = count_ff;

  a_count_off_zero: assert property (@(posedge aclk) disable iff (!aresetn)
    !u.enable |=> count_ff == COUNT_ZERO) else $error("count not cleared while disabled");
  a_miss_clears_count: assert property (@(posedge aclk) disable iff (!aresetn)
    sel && !match |=> count_ff == COUNT_ZERO && !hit_ff) else $error("miss did not clear count");
  a_match_counts_up: assert property (@(posedge aclk) disable iff (!aresetn)
    sel && match && count_ff != u.limit |=> count_ff == LIM_W'($past(count_ff) + COUNT_ONE))
    else $error("match did not advance count");
  a_hit_at_limit: assert property (@(posedge aclk) disable iff (!aresetn)
    sel && match && count_ff == u.limit |=> hit_ff ##1 !hit_ff || $past(sel))
    else $error("limit reached without hit");
  a_disabled_no_hit: assert property (@(posedge aclk) disable iff (!aresetn)
    !u.enable |=> !hit_ff) else $error("hit while compare disabled");
  a_hit_right_channel: assert property (@(posedge aclk) disable iff (!aresetn)
    hit_ff |-> $past(u.res_ch) == $past(u.chan) && $past(u.res_valid))
    else $error("hit from unselected channel");
  a_signed_ge: assert property (@(posedge aclk) disable iff (!aresetn)
    sel && u.fmt && u.cond && $signed(u.res_data) >= $signed(u.thr) && count_ff == u.limit
    |=> hit_ff) else $error("signed compare missed");
endmodule

//--- include/adc_cmp_pkg.sv
package adc_cmp_pkg;
  localparam int NUM_UNITS = 2;
  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;
  localparam int RES_W = 12;
  localparam int CH_W = 3;
  localparam int LIM_W = 4;

  // Register byte addresses
  localparam logic [ADDR_W-1:0] CTRL0_OFS = 8'h28;
  localparam logic [ADDR_W-1:0] CTRL1_OFS = 8'h2c;
  localparam logic [ADDR_W-1:0] STATUS_OFS = 8'h30;
  localparam logic [ADDR_W-1:0] EVT_OFS = 8'h34;
  localparam logic [ADDR_W-1:0] MASK_OFS = 8'h38;
  localparam logic [ADDR_W-1:0] FMT_OFS = 8'h3c;

  // Compare control fields
  localparam int EN_BIT = 0;
  localparam int IE_BIT = 1;
  localparam int COND_BIT = 2;
  localparam int CH_LSB = 3;
  localparam int CH_MSB = 5;
  localparam int LIM_LSB = 8;
  localparam int LIM_MSB = 11;
  localparam int THR_LSB = 16;
  localparam int THR_MSB = 27;
  localparam logic [DATA_W-1:0] CTRL_RW_MASK = 32'h0fff_0f3f;
  localparam logic [DATA_W-1:0] CTRL_RESET = 32'h0000_0000;

  // Status and format register fields
  localparam int FLAG0_BIT = 1;
  localparam int FLAG1_BIT = 2;
  localparam int FMT_BIT = 0;
  localparam logic [NUM_UNITS-1:0] UNITS_ZERO = 2'h0;

  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  localparam logic [LIM_W-1:0] COUNT_ZERO = 4'h0;
  localparam logic [LIM_W-1:0] COUNT_ONE = 4'h1;
endpackage

//--- include/cmp_unit_if.sv
`timescale 1ns/10ps
interface cmp_unit_if;
  import adc_cmp_pkg::*;
  logic enable;
  logic cond;
  logic fmt;
  logic [CH_W-1:0] chan;
  logic [LIM_W-1:0] limit;
  logic [RES_W-1:0] thr;
  logic res_valid;
  logic [CH_W-1:0] res_ch;
  logic [RES_W-1:0] res_data;
  logic hit;
  logic [LIM_W-1:0] count;

  modport ctrl (
    output enable, cond, fmt, chan, limit, thr, res_valid, res_ch, res_data,
    input hit, count
  );
  modport unit (
    input enable, cond, fmt, chan, limit, thr, res_valid, res_ch, res_data,
    output hit, count
  );
endinterface
